// ==== hdl/cud_chan_regs.sv ====
`timescale 1ns/100ps
`default_nettype none

// One channel's three configuration bytes
module cud_chan_regs (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Write port
  input wire logic i_wr,
  input wire cud_pkg::cud_sel_t i_sel,
  input wire logic [7:0] i_wdata,
  // Stored values
  output logic [7:0] o_ctl,
  output logic [7:0] o_tsh,
  output logic [7:0] o_slot_lo
);
  import cud_pkg::*;

  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic [7:0] ctl; // Control byte, reserved bits kept zero
    logic [7:0] tsh; // Bytes per slot and upper mask bits
    logic [7:0] slot_lo; // Lower mask bits
  } cud_chan_t;

  cud_chan_t st_reg;
  cud_chan_t st_next;

  // Next-state: each channel owns its own copy, so no setting leaks across channels
  always_comb begin
    st_next = st_reg;
    if (i_wr) begin
      case (i_sel)
        // Reserved bits 5:4 are dropped so they always read zero
        CUD_SEL_CTL: st_next.ctl = i_wdata & CTL_WRITE_MASK; // [RL15] [RL5]
        CUD_SEL_TSH: st_next.tsh = i_wdata; // [RL10] [RL14]
        CUD_SEL_SLOT_LO: st_next.slot_lo = i_wdata; // [RL10]
        default: st_next = st_reg;
      endcase
    end
  end

  // Register stage, frozen while the clock enable is low
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '{ctl: CTL_RESET, tsh: TSH_RESET, slot_lo: SLOT_LO_RESET};
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  assign o_ctl = st_reg.ctl;
  assign o_tsh = st_reg.tsh;
  assign o_slot_lo = st_reg.slot_lo;

endmodule

`default_nettype wire

// ==== hdl/cud_dma_config.sv ====
// Overview of operation
// [RL1] Channel active only while enable bit set
// [RL2] Software configures fields before enabling channel
// [RL3] Control bit 6 turns wrap-around on
// [RL4] Wrap-around only for isochronous DMA endpoints
// [RL5] Wrap-around setting held separately per channel
// [RL6] Channel and buffer manager both see wrap
// [RL7] Bit 3 picks in or out direction
// [RL8] Bits 2:0 pick endpoint one to seven
// [RL9] Software never assigns endpoint zero
// [RL10] Fourteen-bit slot mask over two bytes
// [RL11] Transfers only in slots with mask set
// [RL12] Transfer direction follows endpoint direction bit
// [RL13] Software writes slot mask before enabling
// [RL14] High byte bits 7:6 give bytes per slot
// [RL15] Control bits 5:4 read as zero
// [RL16] Four channels, three byte registers each
// [RL17] Disabled channel issues no transfer requests
`timescale 1ns/100ps
`default_nettype none

module cud_dma_config (
  // Clock, reset and enable
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  // Microcontroller byte register port
  input wire logic [cud_pkg::ADDR_W-1:0] i_mcu_addr,
  input wire logic i_mcu_wr,
  input wire logic i_mcu_rd,
  input wire logic [cud_pkg::DATA_W-1:0] i_mcu_wdata,
  output logic [cud_pkg::DATA_W-1:0] o_mcu_rdata,
  output logic o_mcu_rvalid,
  // Codec port slot timing
  input wire logic i_slot_strobe,
  input wire logic [cud_pkg::SLOT_W-1:0] i_slot_num,
  // Transfer request to buffer manager and codec port
  output logic o_xfer_req,
  output logic [1:0] o_xfer_chan,
  output logic o_xfer_to_usb,
  output logic [2:0] o_xfer_endpoint,
  output logic [2:0] o_xfer_bytes,
  output logic o_xfer_wrap,
  // Per-channel configuration seen by the buffer manager
  output logic [cud_pkg::NUM_CHANNELS-1:0] o_channel_enable,
  output logic [cud_pkg::NUM_CHANNELS-1:0] o_wrap_buffer_enable,
  output logic [cud_pkg::NUM_CHANNELS-1:0] o_endpoint_direction
);
  import cud_pkg::*;

  // ********************************
  // Reset release
  // ********************************
  typedef struct packed {
    logic s1; // First stage, read only by the second
    logic s2; // Released reset used by everything else
  } cud_rsync_t;

  cud_rsync_t rs_reg;
  // Released reset; the second stage hides any metastability of the first
  logic rst_n;

  // Async assert, two-stage synchronous release
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rs_reg <= '0;
    end else begin
      rs_reg <= '{s1: 1'b1, s2: rs_reg.s1};
    end
  end
  assign rst_n = rs_reg.s2;

  // ********************************
  // Address decode
  // ********************************
  typedef struct packed {
    logic hit;
    logic [1:0] chan;
    cud_sel_t sel;
  } cud_dec_t;

  // Used by both the write and read paths
  function automatic cud_dec_t decode(input logic [15:0] addr);
    cud_dec_t d;
    logic [15:0] base;
    d = '{hit: 1'b0, chan: 2'd0, sel: CUD_SEL_NONE};
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      base = 16'(CTL_BASE + 16'(REGS_PER_CHANNEL * c)); // [RL16]
      if (addr == 16'(base + OFS_CTL)) begin
        d = '{hit: 1'b1, chan: 2'(c), sel: CUD_SEL_CTL};
      end else if (addr == 16'(base + OFS_TSH)) begin
        d = '{hit: 1'b1, chan: 2'(c), sel: CUD_SEL_TSH};
      end else if (addr == 16'(base + OFS_SLOT_LO)) begin
        d = '{hit: 1'b1, chan: 2'(c), sel: CUD_SEL_SLOT_LO};
      end
    end
    return d;
  endfunction

  // Decoded address, shared by the write enables and the read mux
  cud_dec_t dec;
  assign dec = decode(i_mcu_addr);

  // ********************************
  // Channel register sets
  // ********************************
  // Stored bytes, indexed by channel number
  logic [7:0] ctl [NUM_CHANNELS];
  logic [7:0] tsh [NUM_CHANNELS];
  logic [7:0] slot_lo [NUM_CHANNELS];

  // One register set per channel, so no write can reach a neighbour
  for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_chan
    cud_chan_regs u_regs (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(rst_n),
      .i_clk_en(i_clk_en),
      .i_wr(i_mcu_wr && dec.hit && (dec.chan == 2'(g))),
      .i_sel(dec.sel),
      .i_wdata(i_mcu_wdata),
      .o_ctl(ctl[g]),
      .o_tsh(tsh[g]),
      .o_slot_lo(slot_lo[g])
    );
  end

  // ********************************
  // Top-level state
  // ********************************
  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
    logic req;
    logic [1:0] chan;
    logic to_usb;
    logic [2:0] ep;
    logic [2:0] bytes;
    logic wrap;
    logic [NUM_CHANNELS-1:0] en;
    logic [NUM_CHANNELS-1:0] wrapen;
    logic [NUM_CHANNELS-1:0] dir;
  } cud_top_t;

  // Registered state; every top-level output is one field of it
  cud_top_t st_reg;
  cud_top_t st_next;

  // Next-state for read answer, slot requests and mirrored config
  always_comb begin
    logic [MASK_W-1:0] mask;
    logic found;
    mask = '0;
    found = 1'b0;
    st_next = st_reg;
    st_next.req = 1'b0;
    st_next.rvalid = 1'b0;

    // Read answer one cycle after the strobe; unmapped reads give zero
    if (i_mcu_rd) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = UNMAPPED_READ;
      if (dec.hit) begin
        case (dec.sel)
          CUD_SEL_CTL: st_next.rdata = ctl[dec.chan]; // [RL15]
          CUD_SEL_TSH: st_next.rdata = tsh[dec.chan];
          CUD_SEL_SLOT_LO: st_next.rdata = slot_lo[dec.chan];
          default: st_next.rdata = UNMAPPED_READ;
        endcase
      end
    end

    // Config mirrors for the buffer manager
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      st_next.en[c] = ctl[c][CTL_ENABLE_BIT]; // [RL1]
      st_next.wrapen[c] = ctl[c][CTL_WRAP_BIT]; // [RL3] [RL5] [RL6]
      st_next.dir[c] = ctl[c][CTL_DIR_BIT]; // [RL7]
    end

    // Slot service: lowest-numbered enabled channel claiming the slot wins.
    // Overlapping masks are a software fault; the priority only keeps it defined.
    if (i_slot_strobe && (32'(i_slot_num) < MASK_W)) begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        mask = {tsh[c][TSH_MASK_W-1:0], slot_lo[c]}; // [RL10]
        if (!found && ctl[c][CTL_ENABLE_BIT] && mask[i_slot_num]) begin // [RL11] [RL17] [RL1]
          found = 1'b1;
          st_next.req = 1'b1;
          st_next.chan = 2'(c);
          st_next.to_usb = ctl[c][CTL_DIR_BIT]; // [RL12] [RL7]
          st_next.ep = ctl[c][CTL_EP_LSB +: CTL_EP_W]; // [RL8]
          st_next.bytes = 3'({1'b0, tsh[c][TSH_BPS_LSB +: 2]} + 3'd1); // [RL14]
          st_next.wrap = ctl[c][CTL_WRAP_BIT]; // [RL6]
        end
      end
    end
  end

  // Register stage
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (i_clk_en) begin
      st_reg <= st_next;
    end
  end

  // ********************************
  // Outputs, all straight from flops
  // ********************************
  assign o_mcu_rdata = st_reg.rdata;
  assign o_mcu_rvalid = st_reg.rvalid;
  assign o_xfer_req = st_reg.req;
  assign o_xfer_chan = st_reg.chan;
  assign o_xfer_to_usb = st_reg.to_usb;
  assign o_xfer_endpoint = st_reg.ep;
  assign o_xfer_bytes = st_reg.bytes;
  assign o_xfer_wrap = st_reg.wrap;
  assign o_channel_enable = st_reg.en;
  assign o_wrap_buffer_enable = st_reg.wrapen;
  assign o_endpoint_direction = st_reg.dir;

endmodule

`default_nettype wire

// ==== hdl/cud_pkg.sv ====
package cud_pkg;

  // ********************************
  // Geometry
  // ********************************
  localparam int unsigned NUM_CHANNELS = 4;
  localparam int unsigned REGS_PER_CHANNEL = 3;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MASK_W = 14;
  localparam int unsigned SLOT_W = 4;

  // ********************************
  // Register map
  // ********************************
  // Channel n control sits at CTL_BASE + 3*n, high slot byte one above, low slot byte two above
  localparam logic [15:0] CTL_BASE = 16'hFFEE;
  localparam logic [15:0] OFS_CTL = 16'h0000;
  localparam logic [15:0] OFS_TSH = 16'h0001;
  localparam logic [15:0] OFS_SLOT_LO = 16'h0002;
  localparam logic [15:0] SLOT_MAP_HIGH_CH2 = 16'hFFF5;
  localparam logic [15:0] SLOT_MAP_LOW_CH2 = 16'hFFF6;
  localparam logic [15:0] CHANNEL_CONTROL_CH3 = 16'hFFF7;

  // ********************************
  // Control register fields
  // ********************************
  localparam int unsigned CTL_ENABLE_BIT = 7;
  localparam int unsigned CTL_WRAP_BIT = 6;
  localparam int unsigned CTL_DIR_BIT = 3;
  localparam int unsigned CTL_EP_LSB = 0;
  localparam int unsigned CTL_EP_W = 3;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hCF;

  // ********************************
  // High slot byte fields
  // ********************************
  localparam int unsigned TSH_BPS_LSB = 6;
  localparam int unsigned TSH_MASK_W = 6;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] TSH_RESET = 8'h00;
  localparam logic [7:0] SLOT_LO_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ********************************
  // Register select codes
  // ********************************
  typedef enum logic [1:0] {
    CUD_SEL_NONE,
    CUD_SEL_CTL,
    CUD_SEL_TSH,
    CUD_SEL_SLOT_LO
  } cud_sel_t;

endpackage

// ==== tb/cud_dma_config_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checker
// ****
module cud_dma_config_props (
  // Clock and requests
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_mcu_rd,
  input wire logic i_slot_strobe,
  input wire logic [3:0] i_slot_num,
  // Answers
  input wire logic o_mcu_rvalid,
  input wire logic o_xfer_req,
  input wire logic [1:0] o_xfer_chan,
  input wire logic o_xfer_to_usb,
  input wire logic [2:0] o_xfer_bytes,
  input wire logic o_xfer_wrap,
  input wire logic [3:0] o_channel_enable,
  input wire logic [3:0] o_wrap_buffer_enable,
  input wire logic [3:0] o_endpoint_direction
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // Accepted read and accepted slot start
  sequence s_rd; i_mcu_rd && i_clk_en; endsequence
  sequence s_slot; i_slot_strobe && i_clk_en; endsequence
  read_answer_a: assert property (s_rd |=> o_mcu_rvalid) else $error("read unanswered");
  quiet_bus_a: assert property (i_clk_en && !i_mcu_rd |=> !o_mcu_rvalid) else $error("stray read answer");
  // A frozen clock holds the request, so a held one needs no fresh slot
  req_cause_a: assert property (o_xfer_req |->
    $past(i_slot_strobe && i_clk_en && i_slot_num < 14) || $past(!i_clk_en && o_xfer_req))
    else $error("request without slot");
  req_enabled_a: assert property (o_xfer_req |-> o_channel_enable[o_xfer_chan])
    else $error("request from idle channel");
  dir_follow_a: assert property (o_xfer_req |-> o_xfer_to_usb == o_endpoint_direction[o_xfer_chan])
    else $error("direction mismatch");
  wrap_follow_a: assert property (o_xfer_req |-> o_xfer_wrap == o_wrap_buffer_enable[o_xfer_chan])
    else $error("wrap mismatch");
  bytes_range_a: assert property (o_xfer_req |-> o_xfer_bytes inside {[3'd1:3'd4]})
    else $error("byte count out of range");
  high_slot_a: assert property (s_slot ##0 i_slot_num > 13 |=> !o_xfer_req) else $error("slot 14 served");
  // Enable mirrors lag the control byte one cycle, so judge them beside the request
  all_idle_a: assert property (s_slot ##1 o_channel_enable == 0 |-> !o_xfer_req)
    else $error("disabled block served");
endmodule
bind cud_dma_config cud_dma_config_props u_props (.i_sys_clk, .i_arst_n, .i_clk_en, .i_mcu_rd,
  .i_slot_strobe, .i_slot_num, .o_mcu_rvalid, .o_xfer_req, .o_xfer_chan, .o_xfer_to_usb, .o_xfer_bytes,
  .o_xfer_wrap, .o_channel_enable, .o_wrap_buffer_enable, .o_endpoint_direction);
`default_nettype wire

// ==== tb/cud_dma_config_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module cud_dma_config_test;
  import cud_pkg::*;
  // ****
  // Stimulus and observed signals
  // ****
  logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_clk_en = 1'b1, i_mcu_wr = 1'b0, i_mcu_rd = 1'b0;
  logic [15:0] i_mcu_addr = 16'h0000;
  logic [7:0] i_mcu_wdata = 8'h00, o_mcu_rdata, d;
  logic o_mcu_rvalid, o_xfer_req, o_xfer_to_usb, o_xfer_wrap, i_slot_strobe;
  logic [1:0] o_xfer_chan;
  logic [2:0] o_xfer_endpoint, o_xfer_bytes;
  logic [3:0] i_slot_num, o_channel_enable, o_wrap_buffer_enable, o_endpoint_direction;
  int n_errors = 0, n_checks = 0;
  always #10 i_sys_clk = ~i_sys_clk;
  cud_dma_config u_cud_dma_config (.i_sys_clk, .i_arst_n, .i_clk_en, .i_mcu_addr, .i_mcu_wr, .i_mcu_rd,
    .i_mcu_wdata, .o_mcu_rdata, .o_mcu_rvalid, .i_slot_strobe, .i_slot_num, .o_xfer_req, .o_xfer_chan,
    .o_xfer_to_usb, .o_xfer_endpoint, .o_xfer_bytes, .o_xfer_wrap, .o_channel_enable,
    .o_wrap_buffer_enable, .o_endpoint_direction);
  cud_slot_src u_slot_src (.i_sys_clk, .o_slot_strobe(i_slot_strobe), .o_slot_num(i_slot_num));
  // ****
  // Shared tasks
  // ****
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Byte address of register r of channel ch
  function automatic logic [15:0] ad(int ch, int r);
    return CTL_BASE + 16'(3 * ch + r);
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    #1;
    i_mcu_addr = a;
    i_mcu_wdata = v;
    i_mcu_wr = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_mcu_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    #1;
    i_mcu_addr = a;
    i_mcu_rd = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_mcu_rd = 1'b0;
    check("read valid", {7'h0, o_mcu_rvalid}, 8'h01);
    v = o_mcu_rdata;
  endtask
  // ****
  // Scenarios
  // ****
  // All twelve bytes clear, unmapped reads zero, frozen clock takes nothing
  task automatic t_reset_map();
    for (int k = 0; k < 12; k++) begin
      rd(ad(k / 3, k % 3), d);
      check("reset byte", d, 8'h00);
    end
    rd(16'h0000, d);
    check("unmapped", d, 8'h00);
    i_clk_en = 1'b0;
    wr(ad(0, 0), 8'hFF);
    i_clk_en = 1'b1;
    rd(ad(0, 0), d);
    check("frozen write", d, 8'h00);
  endtask
  // Reserved control bits drop, mirrors follow channel 3 alone
  task automatic t_ctl_fields();
    wr(CHANNEL_CONTROL_CH3, 8'hFF);
    rd(CHANNEL_CONTROL_CH3, d);
    check("ctl3", d, 8'hCF);
    check("en wrap", {o_channel_enable, o_wrap_buffer_enable}, 8'h88);
    check("dir", {4'h0, o_endpoint_direction}, 8'h08);
    wr(SLOT_MAP_HIGH_CH2, 8'hFF);
    wr(SLOT_MAP_LOW_CH2, 8'h5A);
    rd(SLOT_MAP_HIGH_CH2, d);
    check("tsh2", d, 8'hFF);
    rd(SLOT_MAP_LOW_CH2, d);
    check("slot low ch2", d, 8'h5A);
    wr(CHANNEL_CONTROL_CH3, 8'h00);
    wr(SLOT_MAP_HIGH_CH2, 8'h00);
    wr(SLOT_MAP_LOW_CH2, 8'h00);
  endtask
  // Channel k serves slot 4k+1 with its own code, wrap and direction
  task automatic t_slots();
    logic [13:0] m;
    for (int k = 0; k < 4; k++) begin
      m = 14'h0001 << (4 * k + 1);
      wr(ad(k, 2), m[7:0]);
      wr(ad(k, 1), {2'(k), m[13:8]});
      wr(ad(k, 0), {1'b1, k[0], 2'b00, ~k[0], 3'(k + 1)});
    end
    for (int k = 0; k < 4; k++) begin
      u_slot_src.fire(4'(4 * k + 1));
      check("req", {7'h0, o_xfer_req}, 8'h01);
      check("chan", {6'h0, o_xfer_chan}, 8'(k));
      check("dir ep", {4'h0, o_xfer_to_usb, o_xfer_endpoint}, {4'h0, ~k[0], 3'(k + 1)});
      check("bytes", {5'h0, o_xfer_bytes}, 8'(k + 1));
      check("wrap", {7'h0, o_xfer_wrap}, {7'h0, k[0]});
      @(posedge i_sys_clk);
      #1;
      check("req pulse", {7'h0, o_xfer_req}, 8'h00);
    end
    // Channel 1 also claims slot 1; the lower channel keeps it
    wr(ad(1, 2), 8'h22);
    u_slot_src.fire(4'd1);
    check("overlap chan", {6'h0, o_xfer_chan}, 8'h00);
    u_slot_src.fire(4'd0);
    check("clear slot", {7'h0, o_xfer_req}, 8'h00);
    u_slot_src.fire(4'd14);
    check("slot 14", {7'h0, o_xfer_req}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(ad(k, 0), 8'h01);
    end
    u_slot_src.fire(4'd1);
    check("disabled", {7'h0, o_xfer_req}, 8'h00);
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    repeat (5) @(posedge i_sys_clk);
    #1;
    i_arst_n = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    t_reset_map();
    t_ctl_fields();
    t_slots();
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== tb/cud_slot_src.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****
// Codec slot timing source
// ****
module cud_slot_src (
  // Clock
  input wire logic i_sys_clk,
  // Slot timing
  output logic o_slot_strobe,
  output logic [3:0] o_slot_num
);
  initial begin
    o_slot_strobe = 1'b0;
    o_slot_num = 4'hF;
  end
  // One-cycle slot start; number inverted after, so a stale value is never trusted
  task automatic fire(input logic [3:0] n);
    @(posedge i_sys_clk);
    #1;
    o_slot_strobe = 1'b1;
    o_slot_num = n;
    @(posedge i_sys_clk);
    #1;
    o_slot_strobe = 1'b0;
    o_slot_num = ~n;
  endtask
endmodule
`default_nettype wire
